// >>> rtl/omwc_pkg.sv
// Purpose: constants and types for the operating mode and wakeup controller
// Assumes: one 50 MHz clock, AXI4-Lite register access
// Notes: offsets are byte addresses
package omwc_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_P1WAKE = 8'hc0;
   localparam logic [7:0] ADDR_OSCMODE = 8'hca;
   localparam logic [7:0] ADDR_STATUS = 8'hd0;
   localparam logic [7:0] P1WAKE_RST = 8'h00;
   // oscillator mode register fields
   localparam int BIT_HOSC_STOP = 1;
   localparam int BIT_SLOW_SEL = 2;
   localparam int BIT_SLEEP_REQ = 3;
   localparam int BIT_GREEN_REQ = 4;
   localparam logic [1:0] CPUM_NORMAL = 2'h0;
   localparam logic [1:0] CPUM_SLEEP = 2'h1;
   localparam logic [1:0] CPUM_GREEN = 2'h2;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int SETTLE_HOSC_CYCLES = 2048;
   localparam int SLOW_DIV = 4;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [2:0] {ST_NORMAL, ST_SLOW, ST_GREEN, ST_SLEEP, ST_SETTLE} omwc_mode_t;

   typedef struct packed {
      logic [7:0] awaddr;
      logic aw_hold;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic w_hold;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic awready;
      logic wready;
      logic arready;
   } omwc_bus_t;

   typedef struct packed {
      omwc_bus_t bus;
      omwc_mode_t mode;
      logic green_from_slow;
      logic [1:0] cpum;
      logic slow_sel;
      logic hosc_stop;
      logic [7:0] p1_wake_en;
      logic [7:0] p0_snap;
      logic [7:0] p1_snap;
      logic [11:0] settle_cnt;
      logic [1:0] div_cnt;
      logic cpu_run;
      logic cpu_tick;
      logic hosc_en;
      logic lrc_en;
      logic wake_pulse;
      logic slow_clk;
   } omwc_state_t;
endpackage : omwc_pkg

// >>> rtl/omwc_top.sv
// Purpose: operating mode sequencer and wakeup controller
// Assumes: pins synchronous to i_clk, i_hosc_tick marks one high oscillator cycle
// Notes: registers over AXI4-Lite; port-1 wake enable is write only
// ------------------------------------------------------------
// Summary of operation
// RULE1: cpu run halted in power-down and green until wakeup or reset
// RULE2: wake sources are port 0 and port 1 level changes and timer zero overflow
// RULE3: power-down wakes only to normal, only on pin change; overflow ignored
// RULE4: green returns to the mode, normal or slow, active before it
// RULE5: power-down wakeup counts 2048 high oscillator cycles before normal mode
// RULE6: green wakeup resumes immediately with no settle count
// RULE7: port 0 always wakes; port 1 pins wake only when enabled
// RULE8: eight port-1 enable bits, 1 enables a pin, cleared at reset
// RULE9: writing sleep request 1 from normal or slow enters power-down
// RULE10: writing slow select 1 in normal switches to slow mode
// RULE11: writing slow select 0 in slow returns to normal mode
// RULE12: writing green request 1 from normal or slow enters green
// RULE13: firmware restarts high oscillator and waits 20ms before leaving slow
// RULE14: in green, timer overflow wakes only when timer run enable is set
// RULE15: without timer wake in green only pins and reset wake
// RULE16: mode field 00 normal, 01 power-down, 10 green, 11 reserved; resets 00
// RULE17: high oscillator stop bit stops high oscillator, low rc keeps running
// RULE18: slow mode instruction tick is low rc clock divided by four
// RULE19: pin change found by comparing pins with values latched at mode entry
// RULE20: any wakeup clears the mode field back to normal
// ------------------------------------------------------------
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module omwc_top #(
   parameter int SETTLE_CYCLES = omwc_pkg::SETTLE_HOSC_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic o_bvalid,
   output logic [1:0] o_bresp,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic [7:0] i_port0,
   input wire logic [7:0] i_port1,
   input wire logic i_timer0_ovf,
   input wire logic i_timer0_run_en,
   input wire logic i_hosc_tick,
   input wire logic i_lrc_tick,
   output logic o_cpu_run,
   output logic o_cpu_tick_slow,
   output logic o_hosc_en,
   output logic o_lrc_en,
   output logic o_slow_clk_sel,
   output logic o_wake_pulse
);
   omwc_pkg::omwc_state_t s_ff, nxt_s;
   logic [11:0] settle_last;
   assign settle_last = 12'(SETTLE_CYCLES - 1);

   function automatic logic [31:0] read_word(input logic [7:0] a, input omwc_pkg::omwc_state_t s);
      logic [31:0] r;
      r = 32'h0;
      if (a == omwc_pkg::ADDR_OSCMODE) begin
         r[omwc_pkg::BIT_GREEN_REQ] = s.cpum[1];
         r[omwc_pkg::BIT_SLEEP_REQ] = s.cpum[0];
         r[omwc_pkg::BIT_SLOW_SEL] = s.slow_sel;
         r[omwc_pkg::BIT_HOSC_STOP] = s.hosc_stop;
      end else if (a == omwc_pkg::ADDR_STATUS) begin
         r[2:0] = s.mode;
         r[3] = s.cpu_run;
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic wr_go;
      logic [31:0] wd;
      logic pin_chg;
      logic wake_green;
      wr_go = 1'b0;
      wd = 32'h0;
      pin_chg = 1'b0;
      wake_green = 1'b0;
      nxt_s = s_ff;
      nxt_s.wake_pulse = 1'b0;
      // bus: address and data captured in either order
      if (i_awvalid && !s_ff.bus.aw_hold) begin
         nxt_s.bus.awaddr = i_awaddr;
         nxt_s.bus.aw_hold = 1'b1;
      end
      if (i_wvalid && !s_ff.bus.w_hold) begin
         nxt_s.bus.wdata = i_wdata;
         nxt_s.bus.wstrb = i_wstrb;
         nxt_s.bus.w_hold = 1'b1;
      end
      if (s_ff.bus.bvalid && i_bready) begin
         nxt_s.bus.bvalid = 1'b0;
      end
      if (s_ff.bus.aw_hold && s_ff.bus.w_hold && !s_ff.bus.bvalid) begin
         wr_go = s_ff.bus.wstrb[0];
         wd = s_ff.bus.wdata;
         nxt_s.bus.aw_hold = 1'b0;
         nxt_s.bus.w_hold = 1'b0;
         nxt_s.bus.bvalid = 1'b1;
         nxt_s.bus.bresp = omwc_pkg::AXI_OKAY;
         if (s_ff.bus.awaddr != omwc_pkg::ADDR_P1WAKE && s_ff.bus.awaddr != omwc_pkg::ADDR_OSCMODE) begin
            nxt_s.bus.bresp = omwc_pkg::AXI_SLVERR;
            wr_go = 1'b0;
         end
      end
      if (s_ff.bus.rvalid && i_rready) begin
         nxt_s.bus.rvalid = 1'b0;
      end
      if (i_arvalid && !s_ff.bus.rvalid) begin
         nxt_s.bus.rvalid = 1'b1;
         nxt_s.bus.rdata = read_word(i_araddr, s_ff);
         nxt_s.bus.rresp = (i_araddr == omwc_pkg::ADDR_OSCMODE || i_araddr == omwc_pkg::ADDR_STATUS ||
                            i_araddr == omwc_pkg::ADDR_P1WAKE) ? omwc_pkg::AXI_OKAY : omwc_pkg::AXI_SLVERR;
      end
      // readies kept in flops so that every output leaves a register
      nxt_s.bus.awready = !nxt_s.bus.aw_hold;
      nxt_s.bus.wready = !nxt_s.bus.w_hold;
      nxt_s.bus.arready = !nxt_s.bus.rvalid;
      // register writes
      if (wr_go && s_ff.bus.awaddr == omwc_pkg::ADDR_P1WAKE) begin
         nxt_s.p1_wake_en = wd[7:0]; // RULE8
      end
      if (wr_go && s_ff.bus.awaddr == omwc_pkg::ADDR_OSCMODE) begin
         nxt_s.hosc_stop = wd[omwc_pkg::BIT_HOSC_STOP]; // RULE17
         nxt_s.slow_sel = wd[omwc_pkg::BIT_SLOW_SEL];
         nxt_s.cpum = {wd[omwc_pkg::BIT_GREEN_REQ], wd[omwc_pkg::BIT_SLEEP_REQ]}; // RULE16
      end
      // wake detection against snapshots
      pin_chg = (i_port0 != s_ff.p0_snap) || |((i_port1 ^ s_ff.p1_snap) & s_ff.p1_wake_en); // RULE7 RULE19
      wake_green = pin_chg || (i_timer0_ovf && i_timer0_run_en); // RULE2 RULE14 RULE15
      // mode machine
      case (s_ff.mode)
         omwc_pkg::ST_NORMAL, omwc_pkg::ST_SLOW: begin
            // snapshot retaken every running cycle, so only a change after entry wakes
            nxt_s.p0_snap = i_port0;
            nxt_s.p1_snap = i_port1;
            if (nxt_s.cpum == omwc_pkg::CPUM_SLEEP) begin
               nxt_s.mode = omwc_pkg::ST_SLEEP; // RULE9
            end else if (nxt_s.cpum == omwc_pkg::CPUM_GREEN) begin
               nxt_s.mode = omwc_pkg::ST_GREEN; // RULE12
               nxt_s.green_from_slow = (s_ff.mode == omwc_pkg::ST_SLOW);
            end else if (s_ff.mode == omwc_pkg::ST_NORMAL && nxt_s.slow_sel) begin
               nxt_s.mode = omwc_pkg::ST_SLOW; // RULE10
            end else if (s_ff.mode == omwc_pkg::ST_SLOW && !nxt_s.slow_sel) begin
               nxt_s.mode = omwc_pkg::ST_NORMAL; // RULE11 RULE13
            end
         end
         omwc_pkg::ST_GREEN: begin
            if (wake_green) begin
               // clocks kept running, so no settle count
               nxt_s.mode = s_ff.green_from_slow ? omwc_pkg::ST_SLOW : omwc_pkg::ST_NORMAL; // RULE4 RULE6
               nxt_s.cpum = omwc_pkg::CPUM_NORMAL; // RULE20
               nxt_s.wake_pulse = 1'b1;
            end
         end
         omwc_pkg::ST_SLEEP: begin
            if (pin_chg) begin
               nxt_s.mode = omwc_pkg::ST_SETTLE; // RULE3
               nxt_s.settle_cnt = 12'h0;
               nxt_s.cpum = omwc_pkg::CPUM_NORMAL; // RULE20
               nxt_s.slow_sel = 1'b0;
               nxt_s.hosc_stop = 1'b0;
               nxt_s.wake_pulse = 1'b1;
            end
         end
         omwc_pkg::ST_SETTLE: begin
            // a stopped oscillator gives no ticks, so the count waits on real cycles
            if (i_hosc_tick) begin
               if (s_ff.settle_cnt == settle_last) begin
                  nxt_s.mode = omwc_pkg::ST_NORMAL; // RULE5
               end else begin
                  nxt_s.settle_cnt = s_ff.settle_cnt + 12'h1;
               end
            end
         end
         default: nxt_s.mode = omwc_pkg::ST_NORMAL;
      endcase
      // instruction tick in slow mode: low rc divided by four
      nxt_s.cpu_tick = 1'b0;
      if (nxt_s.mode == omwc_pkg::ST_SLOW && i_lrc_tick) begin
         nxt_s.div_cnt = s_ff.div_cnt + 2'h1;
         nxt_s.cpu_tick = (s_ff.div_cnt == 2'(omwc_pkg::SLOW_DIV - 1)); // RULE18
      end
      nxt_s.cpu_run = (nxt_s.mode == omwc_pkg::ST_NORMAL || nxt_s.mode == omwc_pkg::ST_SLOW); // RULE1
      nxt_s.hosc_en = (nxt_s.mode != omwc_pkg::ST_SLEEP) && !nxt_s.hosc_stop; // RULE17
      nxt_s.lrc_en = (nxt_s.mode != omwc_pkg::ST_SLEEP);
      nxt_s.slow_clk = (nxt_s.mode == omwc_pkg::ST_SLOW); // RULE10 RULE11
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_ff <= '0;
         s_ff.mode <= omwc_pkg::ST_NORMAL;
         s_ff.p1_wake_en <= omwc_pkg::P1WAKE_RST;
         s_ff.cpu_run <= 1'b1;
         s_ff.hosc_en <= 1'b1;
         s_ff.lrc_en <= 1'b1;
         s_ff.bus.awready <= 1'b1;
         s_ff.bus.wready <= 1'b1;
         s_ff.bus.arready <= 1'b1;
      end else if (i_ce) begin
         s_ff <= nxt_s;
      end
   end

   // ------------------------------------------------------------
   // outputs, each straight from the state register
   // ------------------------------------------------------------
   assign o_awready = s_ff.bus.awready;
   assign o_wready = s_ff.bus.wready;
   assign o_bvalid = s_ff.bus.bvalid;
   assign o_bresp = s_ff.bus.bresp;
   assign o_arready = s_ff.bus.arready;
   assign o_rvalid = s_ff.bus.rvalid;
   assign o_rdata = s_ff.bus.rdata;
   assign o_rresp = s_ff.bus.rresp;
   assign o_cpu_run = s_ff.cpu_run;
   assign o_cpu_tick_slow = s_ff.cpu_tick;
   assign o_hosc_en = s_ff.hosc_en;
   assign o_lrc_en = s_ff.lrc_en;
   assign o_slow_clk_sel = s_ff.slow_clk;
   assign o_wake_pulse = s_ff.wake_pulse;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // antecedents of the |=> checks other than a_settle_hold carry i_ce: a frozen cycle must not be read as a missed step
   a_halt_lowpower: assert property (s_ff.mode inside {omwc_pkg::ST_GREEN, omwc_pkg::ST_SLEEP, // RULE1
      omwc_pkg::ST_SETTLE} |-> !o_cpu_run) else $error("cpu runs in low power");
   a_sleep_no_timer: assert property (i_ce && s_ff.mode == omwc_pkg::ST_SLEEP && !nxt_s.wake_pulse // RULE3
      |=> s_ff.mode == omwc_pkg::ST_SLEEP) else $error("sleep left without pin change");
   a_green_return: assert property (i_ce && s_ff.mode == omwc_pkg::ST_GREEN && s_ff.green_from_slow // RULE4
      && nxt_s.wake_pulse |=> s_ff.mode == omwc_pkg::ST_SLOW) else $error("green did not return to slow");
   a_settle_done: assert property (i_ce && s_ff.mode == omwc_pkg::ST_SETTLE && i_hosc_tick && // RULE5
      s_ff.settle_cnt == settle_last |=> s_ff.mode == omwc_pkg::ST_NORMAL) else $error("settle end missed");
   a_settle_hold: assert property (s_ff.mode == omwc_pkg::ST_SETTLE && s_ff.settle_cnt != settle_last // RULE5
      |=> s_ff.mode == omwc_pkg::ST_SETTLE) else $error("settle cut short");
   a_green_nodelay: assert property (i_ce && s_ff.mode == omwc_pkg::ST_GREEN && nxt_s.wake_pulse // RULE6
      |=> o_cpu_run) else $error("green wake delayed");
   a_p1_masked: assert property (i_ce && s_ff.mode == omwc_pkg::ST_SLEEP && i_port0 == s_ff.p0_snap && // RULE7
      ((i_port1 ^ s_ff.p1_snap) & s_ff.p1_wake_en) == 8'h00 |=> !o_wake_pulse) else $error("masked pin woke");
   a_green_timer: assert property (i_ce && s_ff.mode == omwc_pkg::ST_GREEN && i_timer0_ovf && // RULE14
      i_timer0_run_en |=> o_wake_pulse) else $error("timer did not wake green");
   a_wake_clears: assert property (o_wake_pulse |-> s_ff.cpum == omwc_pkg::CPUM_NORMAL) // RULE20
      else $error("mode field not cleared");
   a_sleep_osc: assert property (s_ff.mode == omwc_pkg::ST_SLEEP |-> !o_hosc_en && !o_lrc_en) // RULE17
      else $error("oscillators run in sleep");
   a_sleep_entry: assert property (i_ce && s_ff.mode inside {omwc_pkg::ST_NORMAL, omwc_pkg::ST_SLOW} && // RULE9
      nxt_s.cpum == omwc_pkg::CPUM_SLEEP |=> s_ff.mode == omwc_pkg::ST_SLEEP) else $error("sleep not entered");
   a_green_entry: assert property (i_ce && s_ff.mode inside {omwc_pkg::ST_NORMAL, omwc_pkg::ST_SLOW} && // RULE12
      nxt_s.cpum == omwc_pkg::CPUM_GREEN |=> s_ff.mode == omwc_pkg::ST_GREEN) else $error("green not entered");
   a_slow_entry: assert property (i_ce && s_ff.mode == omwc_pkg::ST_NORMAL && nxt_s.slow_sel && // RULE10
      nxt_s.cpum == omwc_pkg::CPUM_NORMAL |=> o_slow_clk_sel) else $error("slow mode not entered");
   a_normal_return: assert property (i_ce && s_ff.mode == omwc_pkg::ST_SLOW && !nxt_s.slow_sel && // RULE11
      nxt_s.cpum == omwc_pkg::CPUM_NORMAL |=> s_ff.mode == omwc_pkg::ST_NORMAL) else $error("slow mode not left");
   a_green_hold: assert property (i_ce && s_ff.mode == omwc_pkg::ST_GREEN && i_port0 == s_ff.p0_snap && // RULE15
      ((i_port1 ^ s_ff.p1_snap) & s_ff.p1_wake_en) == 8'h00 && !(i_timer0_ovf && i_timer0_run_en)
      |=> s_ff.mode == omwc_pkg::ST_GREEN) else $error("green left without wake source");
   a_green_pin: assert property (i_ce && s_ff.mode == omwc_pkg::ST_GREEN && i_port0 != s_ff.p0_snap // RULE7 RULE19
      |=> o_wake_pulse) else $error("port 0 change did not wake green");
   a_green_normal: assert property (i_ce && s_ff.mode == omwc_pkg::ST_GREEN && !s_ff.green_from_slow // RULE4
      && nxt_s.wake_pulse |=> s_ff.mode == omwc_pkg::ST_NORMAL) else $error("green did not return to normal");
   a_osc_wake: assert property (i_ce && s_ff.mode == omwc_pkg::ST_SLEEP && nxt_s.wake_pulse // RULE3 RULE5
      |=> s_ff.mode == omwc_pkg::ST_SETTLE && o_hosc_en) else $error("sleep wake skipped settle");
   a_wake_once: assert property (i_ce && o_wake_pulse |=> !o_wake_pulse) // RULE2
      else $error("wake pulse held");
   a_hosc_stop: assert property (s_ff.hosc_stop |-> !o_hosc_en) // RULE17
      else $error("high oscillator runs while stopped");
   a_lrc_runs: assert property (s_ff.mode != omwc_pkg::ST_SLEEP |-> o_lrc_en) // RULE17
      else $error("low rc stopped outside sleep");
   a_tick_slow: assert property (o_cpu_tick_slow |-> o_slow_clk_sel) // RULE18
      else $error("slow tick outside slow mode");

   c_sleep_wake: cover property (s_ff.mode == omwc_pkg::ST_SLEEP ##1 s_ff.mode == omwc_pkg::ST_SETTLE);
   c_green_wake: cover property (s_ff.mode == omwc_pkg::ST_GREEN ##1 o_wake_pulse);
   c_slow_mode: cover property (s_ff.mode == omwc_pkg::ST_SLOW && o_cpu_tick_slow);
   c_settle_done: cover property (s_ff.mode == omwc_pkg::ST_SETTLE ##1 s_ff.mode == omwc_pkg::ST_NORMAL);
   c_timer_wake: cover property (s_ff.mode == omwc_pkg::ST_GREEN && i_timer0_ovf && i_timer0_run_en);
endmodule // omwc_top
`default_nettype wire

// >>> tb/omwc_top_tb_top.sv
// Purpose: self-checking bench for the operating mode and wakeup controller
// Assumes: bench drives every port itself, settle count cut to 8 ticks
// Notes: oscillator ticks are gated by the enables, since a stopped oscillator gives none
`timescale 1ns/100ps
`default_nettype none
module omwc_top_tb_top;
   // ------------------------------------------------------------
   // signals and design instance
   // ------------------------------------------------------------
   localparam int SETTLE = 8;
   localparam logic [7:0] OSC = omwc_pkg::ADDR_OSCMODE;
   logic i_clk = 1'h0;
   logic i_rst = 1'h1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, port0 = 8'h00, port1 = 8'h00, tcnt = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic ovf = 1'h0, run_en = 1'h0, htick = 1'h0, ltick = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, run, tslow, hen, len, ssel, wake;
   logic [1:0] bresp, rresp, resp;
   int bad_count = 0, tests_run = 0, cyc = 0, n;

   omwc_top #(.SETTLE_CYCLES(SETTLE)) omwc_top_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'h1),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
      .o_bvalid(bvalid), .o_bresp(bresp), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_port0(port0), .i_port1(port1), .i_timer0_ovf(ovf), .i_timer0_run_en(run_en),
      .i_hosc_tick(htick), .i_lrc_tick(ltick), .o_cpu_run(run), .o_cpu_tick_slow(tslow),
      .o_hosc_en(hen), .o_lrc_en(len), .o_slow_clk_sel(ssel), .o_wake_pulse(wake));

   initial begin
      forever #10 i_clk = ~i_clk;
   end

   // high osc ticks every 4 cycles, low rc every 2; timeout far above the run length
   always @(posedge i_clk) begin
      tcnt <= tcnt + 8'h01;
      htick <= hen && (tcnt[1:0] == 2'h0);
      ltick <= len && tcnt[0];
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         results();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge i_clk);
         if (awvalid && awready === 1'h1) awvalid <= 1'h0;
         if (wvalid && wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      resp = bresp;
      bready <= 1'h0;
   endtask

   task rdr(input logic [7:0] a);
      @(posedge i_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge i_clk);
         if (arvalid && arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rd = rdata;
      resp = rresp;
      rready <= 1'h0;
   endtask

   task st(input logic r, input omwc_pkg::omwc_mode_t m);
      rdr(omwc_pkg::ADDR_STATUS);
      chk(rd, {28'h0, r, m});
   endtask

   task results;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst <= 1'h0;
      st(1'h1, omwc_pkg::ST_NORMAL);
      rdr(omwc_pkg::ADDR_P1WAKE);
      chk(rd, 32'h0);
      rdr(8'h44);
      chk({30'h0, resp}, {30'h0, omwc_pkg::AXI_SLVERR});
      wr(8'h44, 32'h1f);
      chk({30'h0, resp}, {30'h0, omwc_pkg::AXI_SLVERR});
      st(1'h1, omwc_pkg::ST_NORMAL);
      wr(OSC, 32'h18);
      chk({30'h0, resp}, {30'h0, omwc_pkg::AXI_OKAY});
      st(1'h1, omwc_pkg::ST_NORMAL);
      $display("test reset and map done");
      wr(OSC, 32'h04);
      st(1'h1, omwc_pkg::ST_SLOW);
      chk({31'h0, ssel}, 32'h1);
      n = 0;
      repeat (32) begin
         @(posedge i_clk);
         if (tslow === 1'h1) n++;
      end
      chk(n, 32'h4);
      wr(OSC, 32'h06);
      repeat (2) @(posedge i_clk);
      chk({30'h0, hen, len}, 32'h1);
      wr(OSC, 32'h04);
      repeat (4) @(posedge i_clk);
      wr(OSC, 32'h00);
      st(1'h1, omwc_pkg::ST_NORMAL);
      $display("test slow mode done");
      wr(OSC, 32'h10);
      st(1'h0, omwc_pkg::ST_GREEN);
      ovf <= 1'h1;
      @(posedge i_clk);
      ovf <= 1'h0;
      repeat (3) @(posedge i_clk);
      st(1'h0, omwc_pkg::ST_GREEN);
      port1 <= 8'h80;
      repeat (3) @(posedge i_clk);
      st(1'h0, omwc_pkg::ST_GREEN);
      port0 <= 8'h01;
      repeat (3) @(posedge i_clk);
      st(1'h1, omwc_pkg::ST_NORMAL);
      wr(OSC, 32'h04);
      wr(OSC, 32'h14);
      st(1'h0, omwc_pkg::ST_GREEN);
      run_en <= 1'h1;
      ovf <= 1'h1;
      @(posedge i_clk);
      ovf <= 1'h0;
      @(posedge i_clk);
      chk({31'h0, wake}, 32'h1);
      st(1'h1, omwc_pkg::ST_SLOW);
      $display("test green mode done");
      wr(OSC, 32'h00);
      wr(omwc_pkg::ADDR_P1WAKE, 32'h01);
      wr(OSC, 32'h08);
      st(1'h0, omwc_pkg::ST_SLEEP);
      chk({30'h0, hen, len}, 32'h0);
      port1 <= 8'h02;
      ovf <= 1'h1;
      @(posedge i_clk);
      ovf <= 1'h0;
      repeat (4) @(posedge i_clk);
      st(1'h0, omwc_pkg::ST_SLEEP);
      port1 <= 8'h03;
      n = 0;
      do begin
         @(posedge i_clk);
         if (htick === 1'h1) n++;
      end while (run !== 1'h1);
      chk(n, SETTLE);
      st(1'h1, omwc_pkg::ST_NORMAL);
      wr(OSC, 32'h08);
      port0 <= 8'h00;
      do @(posedge i_clk); while (run !== 1'h1);
      st(1'h1, omwc_pkg::ST_NORMAL);
      $display("test power-down done");
      results();
   end
endmodule // omwc_top_tb_top
`default_nettype wire
